// >>> verilog/gdr_pkg.sv
// constants shared by the gpio data register block: register offsets,
// reset values, direction encoding and synchroniser depth.
// assumes a 32-bit register port whose address carries full byte addresses.
package gdr_pkg;

   // bank geometry
   localparam int          BANK_W           = 32;
   localparam int          NUM_BANKS        = 3;
   localparam int          MAX_BANKS        = 3;

   // byte addresses of the output latch registers
   localparam logic [31:0] OUT_LATCH_BANK0  = 32'hD00A0018;
   localparam logic [31:0] OUT_LATCH_BANK1  = 32'hD00A001C;
   localparam logic [31:0] OUT_LATCH_BANK2  = 32'hD00A0020;

   // byte addresses of the input sample registers
   localparam logic [31:0] IN_SAMPLE_BANK0  = 32'hD00A0024;
   localparam logic [31:0] IN_SAMPLE_BANK1  = 32'hD00A0028;
   localparam logic [31:0] IN_SAMPLE_BANK2  = 32'hD00A002C;

   // tables indexed by bank number
   localparam logic [MAX_BANKS-1:0][31:0] OUT_ADDR =
      {OUT_LATCH_BANK2, OUT_LATCH_BANK1, OUT_LATCH_BANK0};
   localparam logic [MAX_BANKS-1:0][31:0] IN_ADDR =
      {IN_SAMPLE_BANK2, IN_SAMPLE_BANK1, IN_SAMPLE_BANK0};

   // values after reset
   localparam logic [31:0] OUT_RESET        = 32'h00000000;
   localparam logic [31:0] IN_RESET         = 32'h00000000;
   localparam logic [31:0] DIR_RESET        = 32'hFFFFFFFF;
   localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;

   // direction bit encoding
   localparam logic        DIR_OUTPUT       = 1'b0;
   localparam logic        DIR_INPUT        = 1'b1;

   // cycles from a register read strobe to its data
   localparam int          READ_LATENCY     = 1;
   // flip-flop stages on each pin input
   localparam int          SYNC_STAGES      = 2;

endpackage : gdr_pkg

// >>> verilog/gdr_sync.sv
// two-stage synchroniser for a vector of pin levels.
// assumes each bit is an independent level; no bus coherence is promised.
module gdr_sync #(
   parameter int WIDTH = 96
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage_one;

   // first stage feeds only the second stage, nothing else looks at it
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         stage_one <= '0;
         level_out <= '0;
      end
      else
      begin
         stage_one <= level_in;
         level_out <= stage_one;
      end
   end

endmodule : gdr_sync

// >>> verilog/gdr_pad_drive.sv
// per-pin output stage: chooses between gpio drive and the pin's own
// function, and registers the result so the pads see clean levels.
// assumes enable and direction arrive already stable from their registers.
module gdr_pad_drive #(
   parameter int WIDTH = 96
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // gpio control
   input  wire logic [WIDTH-1:0] gpio_enable,
   input  wire logic [WIDTH-1:0] pin_is_output,
   input  wire logic [WIDTH-1:0] pin_latch,
   // primary or alternate function
   input  wire logic [WIDTH-1:0] alt_out,
   input  wire logic [WIDTH-1:0] alt_oe,
   // pads
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe
);

   logic [WIDTH-1:0] next_pin_out;
   logic [WIDTH-1:0] next_pin_oe;

   // per-pin selection; a disabled pin is handed to its own function
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_pin
      assign next_pin_out[i] = gpio_enable[i] ? pin_latch[i] : alt_out[i];
      assign next_pin_oe[i]  = gpio_enable[i] ? pin_is_output[i] : alt_oe[i];
   end

   // pads start released so nothing fights an external driver at power-up
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pin_out <= '0;
         pin_oe  <= '0;
      end
      else
      begin
         pin_out <= next_pin_out;
         pin_oe  <= next_pin_oe;
      end
   end

endmodule : gdr_pad_drive

// >>> verilog/gdr_top.sv
// data path of the general purpose i/o port: output latch and input sample
// registers, pin drive selection and input synchronisation.
// assumes enable and direction registers live outside and arrive as vectors,
// and a master that keeps strobes one cycle long and never both at once.
//
// Summary of operation
// [RULE1] a latch write captures the written bit for every pin set as output
// [RULE2] written bits of input pins leave the pin latch and pins untouched
// [RULE3] latch readback returns the last written word, whatever the direction
// [RULE4] sample readback shows the synchronised pin level for input pins
// [RULE5] sample readback shows the latched value for output pins
// [RULE6] a pin is gpio-driven only while enabled, else carries its own function
// [RULE7] direction 0 means output, 1 means input; directions reset to input
// [RULE8] software sets direction and latch before enabling an output pin
// [RULE9] pin levels pass two flip-flops before being sampled or read
module gdr_top #(
   parameter int NBANK = gdr_pkg::NUM_BANKS
) (
   // clock and reset
   input  wire logic                              clock,
   input  wire logic                              reset,
   // register port
   input  wire logic [31:0]                       address,
   input  wire logic [31:0]                       write_data,
   input  wire logic                              write_strobe,
   input  wire logic                              read_strobe,
   output logic      [31:0]                       read_data,
   // control from the neighbouring enable and direction registers
   input  wire logic [NBANK*gdr_pkg::BANK_W-1:0]  gpio_enable,
   input  wire logic [NBANK*gdr_pkg::BANK_W-1:0]  gpio_dir,
   // primary or alternate function side
   input  wire logic [NBANK*gdr_pkg::BANK_W-1:0]  alt_out,
   input  wire logic [NBANK*gdr_pkg::BANK_W-1:0]  alt_oe,
   output logic      [NBANK*gdr_pkg::BANK_W-1:0]  alt_in,
   // pads
   input  wire logic [NBANK*gdr_pkg::BANK_W-1:0]  pin_in,
   output logic      [NBANK*gdr_pkg::BANK_W-1:0]  pin_out,
   output logic      [NBANK*gdr_pkg::BANK_W-1:0]  pin_oe
);

   localparam int BW    = gdr_pkg::BANK_W;
   localparam int PIN_W = NBANK * BW;

   // the address map holds only as many banks as there are printed offsets
   if (NBANK < 1 || NBANK > gdr_pkg::MAX_BANKS)
   begin : g_bad_nbank
      $error("gdr_top: NBANK must be between 1 and MAX_BANKS");
   end

   // storage
   logic [PIN_W-1:0]   written_value;   // last word written, per bank
   logic [PIN_W-1:0]   pin_latch;       // level presented by output pins
   logic [PIN_W-1:0]   next_written;
   logic [PIN_W-1:0]   next_pin_latch;
   logic [31:0]        next_read_data;

   // decode and selection nets
   wire  [NBANK-1:0]   out_hit;
   wire  [NBANK-1:0]   in_hit;
   wire  [PIN_W-1:0]   write_bit_sel;
   wire  [PIN_W-1:0]   write_data_rep;
   wire  [PIN_W-1:0]   pin_is_output;
   wire  [PIN_W-1:0]   latch_mask;
   wire  [PIN_W-1:0]   pin_sync;
   wire  [PIN_W-1:0]   in_view;
   wire  [NBANK:0][31:0] read_chain;

   // pin inputs pass two flip-flops; the same copy feeds the alternate side
   // bits settle independently, so a word read while pins move may mix edges
   gdr_sync #(
      .WIDTH     (PIN_W)
   ) u_sync (
      .clock     (clock),
      .reset     (reset),
      .level_in  (pin_in),
      .level_out (pin_sync)                                     // [RULE9]
   );

   assign alt_in = pin_sync;

   // direction decode: only a bit equal to the output code drives
   assign pin_is_output = ~(gpio_dir ^ {PIN_W{gdr_pkg::DIR_OUTPUT}}); // [RULE7]

   // per-bank address decode and write fan-out
   for (genvar b = 0; b < NBANK; b++)
   begin : g_bank
      assign out_hit[b]                = (address == gdr_pkg::OUT_ADDR[b]);
      assign in_hit[b]                 = (address == gdr_pkg::IN_ADDR[b]);
      assign write_bit_sel[b*BW +: BW] = {BW{write_strobe & out_hit[b]}};
      assign write_data_rep[b*BW +: BW] = write_data;
      // unmapped addresses fall through the chain as zero
      assign read_chain[b+1] = read_chain[b]
                             | ({32{out_hit[b]}} & written_value[b*BW +: BW])
                             | ({32{in_hit[b]}}  & in_view[b*BW +: BW]);
   end

   assign read_chain[0] = gdr_pkg::UNMAPPED_READ;

   // the latch only takes bits of output pins; input bits are dropped.
   // capture looks at direction only, not enable, so software can preload a
   // pin's level before handing it to gpio; the readback copy keeps the rest
   assign latch_mask     = write_bit_sel & pin_is_output;          // [RULE1] [RULE2]
   assign next_pin_latch = (pin_latch & ~latch_mask)
                         | (write_data_rep & latch_mask);          // [RULE1]

   // the readback copy keeps every written bit regardless of direction
   assign next_written   = (written_value & ~write_bit_sel)
                         | (write_data_rep & write_bit_sel);       // [RULE3]

   // input pins show the pad, output pins the latched value
   assign in_view = (~pin_is_output & pin_sync)                    // [RULE4]
                  | (pin_is_output & pin_latch);                   // [RULE5]

   // read data only stand in the cycle after the strobe, zero otherwise
   // zeroing the idle value keeps stale words off the port between reads
   assign next_read_data = read_strobe ? read_chain[NBANK] : gdr_pkg::UNMAPPED_READ;

   // latch and readback copy
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         written_value <= {NBANK{gdr_pkg::OUT_RESET}};
         pin_latch     <= {NBANK{gdr_pkg::OUT_RESET}};
      end
      else
      begin
         written_value <= next_written;
         pin_latch     <= next_pin_latch;
      end
   end

   // registered read port; a read never stalls the master
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         read_data <= gdr_pkg::IN_RESET;
      end
      else
      begin
         read_data <= next_read_data;
      end
   end

   // pad stage; software is expected to program direction and latch before
   // setting enable, otherwise the pin may briefly show a stale level
   gdr_pad_drive #(
      .WIDTH         (PIN_W)
   ) u_pad (
      .clock         (clock),
      .reset         (reset),
      .gpio_enable   (gpio_enable),                             // [RULE6]
      .pin_is_output (pin_is_output),
      .pin_latch     (pin_latch),
      .alt_out       (alt_out),
      .alt_oe        (alt_oe),
      .pin_out       (pin_out),
      .pin_oe        (pin_oe)
   );

   // ---------------------------------------------------------------------
   // checks on the pin latch
   // ---------------------------------------------------------------------

   // an output bit of a latch write lands in the latch one edge later
   a_latch_takes_out: assert property (                         // [RULE1]
      @(posedge clock) disable iff (reset)
      (|latch_mask) |=> (((pin_latch ^ $past(write_data_rep)) & $past(latch_mask)) == '0)
   ) else $error("output pin bit not captured by latch write");

   // the latch never changes on a bit that the write did not select as output
   a_input_write_ignored: assert property (                     // [RULE2]
      @(posedge clock) disable iff (reset)
      !$past(reset) |-> (((pin_latch ^ $past(pin_latch)) & ~$past(latch_mask)) == '0)
   ) else $error("latch changed on an input pin or without a write");

   // the readback copy takes the whole written word, input bits included
   a_copy_whole_word: assert property (                         // [RULE3]
      @(posedge clock) disable iff (reset)
      (|write_bit_sel) |=> (((written_value ^ $past(write_data_rep)) & $past(write_bit_sel)) == '0)
   ) else $error("readback copy missed written bits");

   // without a write strobe on a bank the readback copy holds still
   a_copy_holds: assert property (                              // [RULE3]
      @(posedge clock) disable iff (reset)
      !$past(reset) |-> (((written_value ^ $past(written_value)) & ~$past(write_bit_sel)) == '0)
   ) else $error("readback copy changed without a write");

   // a write never moves the pad of an enabled input pin
   a_input_pad_kept: assert property (                          // [RULE2]
      @(posedge clock) disable iff (reset)
      (|write_bit_sel) |=> ##1
         (((pin_out ^ $past(pin_out)) & $past(write_bit_sel, 2) & ~$past(pin_is_output, 2)
          & $past(gpio_enable, 2) & $past(gpio_enable)) == '0)
   ) else $error("write moved the pad of an input pin");

   // ---------------------------------------------------------------------
   // checks on the pads
   // ---------------------------------------------------------------------

   // enabled pins: enable follows direction, level follows the latch
   a_gpio_pad_drive: assert property (                          // [RULE7]
      @(posedge clock) disable iff (reset)
      !$past(reset) |->
         ((((pin_oe ^ $past(pin_is_output))
          | ((pin_out ^ $past(pin_latch)) & $past(pin_is_output)))
          & $past(gpio_enable)) == '0)
   ) else $error("enabled pin not driven from direction and latch");

   // disabled pins carry their own function untouched
   a_alt_passthru: assert property (                            // [RULE6]
      @(posedge clock) disable iff (reset)
      !$past(reset) |->
         ((((pin_oe ^ $past(alt_oe)) | (pin_out ^ $past(alt_out)))
          & ~$past(gpio_enable)) == '0)
   ) else $error("disabled pin does not carry its own function");

   // an enabled input pin is never driven, so nothing fights the outside level
   a_input_released: assert property (                          // [RULE7]
      @(posedge clock) disable iff (reset)
      !$past(reset) |-> ((pin_oe & $past(gpio_enable) & $past(gpio_dir)) == '0)
   ) else $error("enabled input pin is being driven");

   // a latch write reaches an enabled output pad two edges later
   a_write_to_pad: assert property (                            // [RULE1]
      @(posedge clock) disable iff (reset)
      ((|latch_mask) && $stable(gpio_enable)) |=>
         ##1 ((($past(write_data_rep, 2) ^ pin_out)
              & $past(latch_mask, 2) & $past(gpio_enable, 2)
              & $past(gpio_enable)) == '0)
   ) else $error("latched output level did not reach the pad");

   // ---------------------------------------------------------------------
   // checks on synchronisation and the read port
   // ---------------------------------------------------------------------

   // pin levels appear exactly two edges after they were applied
   a_sync_two_stage: assert property (                          // [RULE9]
      @(posedge clock) disable iff (reset)
      (!$past(reset) && !$past(reset, 2)) |-> (pin_sync == $past(pin_in, 2))
   ) else $error("pin level not delayed by two stages");

   // no read strobe, no data on the port
   a_read_one_cycle: assert property (
      @(posedge clock) disable iff (reset)
      !read_strobe |=> (read_data == gdr_pkg::UNMAPPED_READ)
   ) else $error("read data present without a read strobe");

   // an unmapped read answers zero
   a_unmapped_zero: assert property (
      @(posedge clock) disable iff (reset)
      (read_strobe && !(|out_hit) && !(|in_hit)) |=> (read_data == gdr_pkg::UNMAPPED_READ)
   ) else $error("unmapped read returned nonzero data");

   // reset leaves the read port quiet and every pad released
   a_reset_quiet: assert property (
      @(posedge clock)
      reset |=> ((read_data == gdr_pkg::UNMAPPED_READ) && (pin_oe == '0) && (pin_out == '0))
   ) else $error("outputs not cleared by reset");

   // reset clears both copies of the output latch
   a_reset_latches_zero: assert property (
      @(posedge clock)
      reset |=> ((pin_latch == {NBANK{gdr_pkg::OUT_RESET}}) && (written_value == {NBANK{gdr_pkg::OUT_RESET}}))
   ) else $error("latches not cleared by reset");

   // per-bank read checks
   for (genvar b = 0; b < NBANK; b++)
   begin : g_check
      // a written word reads back whole, input bits included
      a_written_any_dir: assert property (                      // [RULE3]
         @(posedge clock) disable iff (reset)
         (write_strobe && out_hit[b]) |=> ##1 !$past(write_strobe) && $past(read_strobe)
            && $past(out_hit[b]) |-> (read_data == $past(write_data, 2))
      ) else $error("latch readback differs from last write");

      // latch readback reflects the readback copy
      a_readback_written: assert property (                     // [RULE3]
         @(posedge clock) disable iff (reset)
         (read_strobe && out_hit[b]) |=> (read_data == $past(written_value[b*BW +: BW]))
      ) else $error("latch readback wrong");

      // sample readback: input bits show the synchronised pad
      a_sample_input: assert property (                         // [RULE4]
         @(posedge clock) disable iff (reset)
         (read_strobe && in_hit[b]) |=>
            (((read_data ^ $past(pin_in[b*BW +: BW], 3))
             & ~$past(pin_is_output[b*BW +: BW])) == '0)
            || $past(reset, 3) || $past(reset, 2)
      ) else $error("sample readback of input pin wrong");

      // sample readback: output bits show the latch
      a_sample_output: assert property (                        // [RULE5]
         @(posedge clock) disable iff (reset)
         (read_strobe && in_hit[b]) |=>
            (((read_data ^ $past(pin_latch[b*BW +: BW]))
             & $past(pin_is_output[b*BW +: BW])) == '0)
      ) else $error("sample readback of output pin wrong");
   end

endmodule : gdr_top

// >>> sim/gdr_pad_model.sv
// pad model for the gpio data registers: resolves each pin from the
// design's drive and the external world's level.
// assumes the outside always drives a pin the design has released.
module gdr_pad_model #(
   parameter int WIDTH = 96
) (
   // design side of the pads
   input  wire logic [WIDTH-1:0] pin_out,
   input  wire logic [WIDTH-1:0] pin_oe,
   // level the external world puts on released pins
   input  wire logic [WIDTH-1:0] ext_level,
   // resolved pad levels back into the design
   output logic      [WIDTH-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // a driven pin shows the design's level, a released one the outside's
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gdr_pad_model

// >>> sim/tb_top.sv
// self-checking bench for gdr_top: register port tasks, pad model,
// one task per scenario.
// assumes enable and direction come from the bench in place of their registers.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic [31:0] address = 32'h00000000;
   logic [31:0] write_data = 32'h00000000;
   logic        write_strobe = 1'b0;
   logic        read_strobe = 1'b0;
   logic [31:0] read_data;
   logic [95:0] gpio_enable = '0;
   logic [95:0] gpio_dir = '1; // direction source resets to all inputs
   logic [95:0] alt_out = '0;
   logic [95:0] alt_oe = '0;
   logic [95:0] alt_in;
   logic [95:0] pin_in;
   logic [95:0] pin_out;
   logic [95:0] pin_oe;
   logic [95:0] ext_level = '0;
   int          mismatches = 0;
   int          checks = 0;

   // 100 MHz clock
   always #5 clock = ~clock;

   gdr_top #(.NBANK(3)) gdr_top_i (
      .clock(clock), .reset(reset), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .gpio_enable(gpio_enable), .gpio_dir(gpio_dir), .alt_out(alt_out), .alt_oe(alt_oe),
      .alt_in(alt_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
   );

   gdr_pad_model #(.WIDTH(96)) gdr_pad_model_i (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in)
   );

   // comparison with case equality so an unknown never matches
   task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one-cycle write strobe, launched right after an edge
   task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      write_strobe <= 1'b1;
      address      <= a;
      write_data   <= d;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask : reg_write

   // read data stand only in the cycle after the strobe, so look mid-cycle
   task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
      @(posedge clock);
      read_strobe <= 1'b1;
      address     <= a;
      @(posedge clock);
      read_strobe <= 1'b0;
      @(negedge clock);
      d = read_data;
   endtask : reg_read

   // write then read the same register back to back, with no idle cycle
   task automatic reg_write_read(input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
      @(posedge clock);
      write_strobe <= 1'b1;
      address      <= a;
      write_data   <= wd;
      @(posedge clock);
      write_strobe <= 1'b0;
      read_strobe  <= 1'b1;
      @(posedge clock);
      read_strobe  <= 1'b0;
      @(negedge clock);
      d = read_data;
   endtask : reg_write_read

   // all registers zero after reset, unmapped reads zero, idle bus zero
   task automatic test_reset;
      logic [31:0] d;
      for (int k = 0; k < 3; k++)
      begin
         reg_read(gdr_pkg::OUT_ADDR[k], d);
         check("latch reset", d, gdr_pkg::OUT_RESET);
         reg_read(gdr_pkg::IN_ADDR[k], d);
         check("sample reset", d, gdr_pkg::IN_RESET);
      end
      reg_read(32'hD00A0030, d);
      check("unmapped read", d, gdr_pkg::UNMAPPED_READ);
      @(negedge clock);
      check("idle read data", read_data, 32'h00000000);
      check("pads released", pin_oe, '0);
      $display("test reset done");
   endtask : test_reset

   // a pad change is hidden for two cycles, then readable
   task automatic test_sync;
      logic [31:0] d;
      @(posedge clock);
      ext_level <= {32'h3C3C3C3C, 32'hC3C3C3C3, 32'h96969696};
      reg_read(gdr_pkg::IN_ADDR[0], d);
      check("sample early", d, 32'h00000000);
      reg_read(gdr_pkg::IN_ADDR[0], d);
      check("sample bank0", d, 32'h96969696);
      reg_read(gdr_pkg::IN_ADDR[2], d);
      check("sample bank2", d, 32'h3C3C3C3C);
      $display("test sync done");
   endtask : test_sync

   // disabled pins carry their own function both ways
   task automatic test_alt;
      @(posedge clock);
      alt_out <= {3{32'hF0F0F0F0}};
      alt_oe  <= {3{32'h00FF00FF}};
      repeat (3) @(posedge clock);
      @(negedge clock);
      check("alt pin_out", pin_out, {3{32'hF0F0F0F0}});
      check("alt pin_oe", pin_oe, {3{32'h00FF00FF}});
      check("alt_in", alt_in, ({3{32'h00F000F0}} | ({3{32'hFF00FF00}} & ext_level)));
      $display("test alt done");
   endtask : test_alt

   // latch capture by direction, readback, sample view, pad drive
   task automatic test_data;
      logic [31:0] d;
      logic [31:0] w;
      w = 32'hA5C35A3C;
      @(posedge clock);
      alt_out  <= '0; // hand every released pad back to the outside level
      alt_oe   <= '0;
      gpio_dir <= {3{32'h0000FFFF}}; // direction and latch set before enable
      for (int k = 0; k < 3; k++)
      begin
         reg_write_read(gdr_pkg::OUT_ADDR[k], w, d);
         check("latch readback", d, w);
         reg_read(gdr_pkg::IN_ADDR[k], d);
         check("sample mixed", d, (w & 32'hFFFF0000) | (ext_level[32*k +: 32] & 32'h0000FFFF));
      end
      reg_write(gdr_pkg::IN_ADDR[0], 32'hFFFFFFFF);
      reg_write(32'hD00A0030, 32'hFFFFFFFF);
      reg_read(gdr_pkg::OUT_ADDR[0], d);
      check("ignored writes", d, w);
      @(posedge clock);
      gpio_enable <= '1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      check("gpio pin_oe", pin_oe, {3{32'hFFFF0000}});
      check("gpio pin_out", pin_out & {3{32'hFFFF0000}}, {3{w & 32'hFFFF0000}});
      reg_write(gdr_pkg::OUT_ADDR[0], ~w);
      repeat (2) @(posedge clock);
      @(negedge clock);
      check("pad follows write", pin_out[31:0], ~w & 32'hFFFF0000);
      reg_write(gdr_pkg::OUT_ADDR[0], w);
      @(posedge clock);
      gpio_dir <= '0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      check("input bits not latched", pin_out, {3{w & 32'hFFFF0000}});
      reg_read(gdr_pkg::IN_ADDR[1], d);
      check("sample of pin latch", d, w & 32'hFFFF0000);
      reg_read(gdr_pkg::OUT_ADDR[1], d);
      check("readback whole word", d, w);
      $display("test data done");
   endtask : test_data

   // counts, verdict, end of run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // main sequence
   initial
   begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      test_reset;
      test_sync;
      test_alt;
      test_data;
      tally_and_finish;
   end

   // the tests need well under 2000 cycles
   initial
   begin
      #100us;
      mismatches++;
      $display("watchdog expired");
      tally_and_finish;
   end
endmodule : tb_top
